/* dv/switch_driver_model.sv */
// switch driver model: resolves the four output pins behind their gate-driver pull-downs
`timescale 1ns/10ps
module switch_driver_model (
  // levels and active-low enables from the block
  input wire logic [3:0] drive_level,
  input wire logic [3:0] drive_oe_n,
  // levels as the switch drivers see them
  output logic [3:0] pin_level
);
  // a released pin falls to the pull-down, so a stale level never passes for a driven one
  assign pin_level = drive_level & ~drive_oe_n;
endmodule

/* dv/tb_waveform_steering_shutdown.sv */
// self-checking bench for the steering and shutdown block over axi4-lite
`timescale 1ns/10ps
module tb_waveform_steering_shutdown;
  import wave_steer_pkg::*;
  logic ref_clk = 0, sys_rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic db_done = 0, sd_cond = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [13:0] wave_src = 14'h0000;
  logic [3:0] mode_wave = 4'h0, inv;
  wire [3:0] outs, oe_n, pins;
  logic awready, wready, bvalid, arready, rvalid, m_en, clk_val, irq;
  logic [1:0] bresp, rresp;
  logic [2:0] mode_f;
  logic [31:0] rdata;
  logic [15:0] seed = 16'd3688;
  logic [7:0] r, st;
  int n_fail = 0, total_checks = 0, n_irq = 0, k0;
  always #5 ref_clk = ~ref_clk;
  // count one-cycle flag pulses away from the launching edge
  always @(negedge ref_clk) if (irq === 1'b1) n_irq++;
  waveform_steering_shutdown #(.NUM_SRC(14)) dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .WAVE_SRC(wave_src), .MODE_WAVE(mode_wave), .DEADBAND_DONE(db_done), .SHUTDOWN_COND(sd_cond),
    .MODULE_ENABLE(m_en), .MODE_FIELD(mode_f), .MODULE_CLOCK_VALUE(clk_val),
    .GENERATOR_INTERRUPT_FLAG(irq),
    .WAVEFORM_OUTPUT_A(outs[0]), .WAVEFORM_OUTPUT_A_OE_N(oe_n[0]),
    .WAVEFORM_OUTPUT_B(outs[1]), .WAVEFORM_OUTPUT_B_OE_N(oe_n[1]),
    .WAVEFORM_OUTPUT_C(outs[2]), .WAVEFORM_OUTPUT_C_OE_N(oe_n[2]),
    .WAVEFORM_OUTPUT_D(outs[3]), .WAVEFORM_OUTPUT_D_OE_N(oe_n[3]));
  switch_driver_model drv (.drive_level(outs), .drive_oe_n(oe_n), .pin_level(pins));

  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction
  // steering: enabled outputs carry data with polarity, others their override bit
  function automatic logic [7:0] exp_steer(logic d, logic [3:0] pol, logic [7:0] s);
    return {4'h0, (s[3:0] & ({4{d}} ^ pol)) | (~s[3:0] & s[7:4])};
  endfunction
  // shutdown levels per pair: a floating pin reads low through the pull-down
  function automatic logic [7:0] exp_halt(logic [1:0] bd, logic [1:0] ac, logic [3:0] pol);
    logic [7:0] e;
    logic [1:0] c;
    e = 8'h00;
    for (int i = 0; i < 4; i++) begin
      c = i[0] ? bd : ac;
      case (c)
        2'h3: e[i] = 1'b1;
        2'h2: e[i] = 1'b0;
        2'h1: e[i+4] = 1'b1;
        default: e[i] = pol[i];
      endcase
    end
    return e;
  endfunction

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 100) begin
      n_fail++;
      $display("CHECK FAILED at %0t: bus wait ran out", $time);
      finish_test();
    end
  endtask
  // one write; address and data released separately as each is taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic ap, wp, ha, hw;
    logic [1:0] rs;
    @(posedge ref_clk);
    awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= a; wdata <= {24'h00_0000, d}; bready <= 1'b1;
    ap = 1; wp = 1; n = 0;
    while ((ap || wp) && n < 100) begin
      @(negedge ref_clk);
      ha = ap && awready === 1'b1;
      hw = wp && wready === 1'b1;
      @(posedge ref_clk);
      if (ha) begin awvalid <= 1'b0; ap = 0; end
      if (hw) begin wvalid <= 1'b0; wp = 0; end
      n++;
    end
    while (n < 100) begin @(negedge ref_clk); if (bvalid === 1'b1) break; n++; end
    rs = bresp;
    @(posedge ref_clk);
    bready <= 1'b0;
    guard(n);
    chk({6'h00, rs}, {6'h00, er}, "write response");
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
    int n;
    logic [31:0] d;
    logic [1:0] rs;
    @(posedge ref_clk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1; n = 0;
    while (n < 100) begin @(negedge ref_clk); if (arready === 1'b1) break; n++; end
    @(posedge ref_clk);
    arvalid <= 1'b0;
    while (n < 100) begin @(negedge ref_clk); if (rvalid === 1'b1) break; n++; end
    d = rdata; rs = rresp;
    @(posedge ref_clk);
    rready <= 1'b0;
    guard(n);
    chk({6'h00, rs}, {6'h00, er}, "read response");
    if (er == RESP_OKAY) chk(d[7:0], exp, "read data");
  endtask
  task automatic put_data(input logic [3:0] src, input logic v);
    logic [13:0] m;
    m = 14'h0001 << src;
    @(posedge ref_clk);
    wave_src <= (14'({rnd(), rnd()}) & ~m) | (v ? m : 14'h0000);
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic pins_are(input logic [7:0] e);
    chk({oe_n, pins}, e, "pins");
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    pins_are(8'h00);
    // reset values and two unmapped places
    rd(OFF_POLARITY, 8'h00, RESP_OKAY); rd(OFF_CLOCK_SEL, 8'h00, RESP_OKAY);
    rd(OFF_DATA_SEL, 8'h00, RESP_OKAY); rd(OFF_STEERING, 8'h00, RESP_OKAY);
    rd(OFF_SHUTDOWN, 8'h14, RESP_OKAY); rd(8'h18, 8'h00, RESP_SLVERR);
    wr(8'h1C, 8'hFF, RESP_SLVERR);
    $display("test reset_values done");
    // random write and readback, unimplemented bits masked, input level read-only
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      wr(OFF_CLOCK_SEL, r, RESP_OKAY); rd(OFF_CLOCK_SEL, r & 8'h01, RESP_OKAY);
      chk({7'h00, clk_val}, r & 8'h01, "clock select");
      wr(OFF_DATA_SEL, r, RESP_OKAY); rd(OFF_DATA_SEL, r & 8'h0F, RESP_OKAY);
      wr(OFF_POLARITY, r, RESP_OKAY); rd(OFF_POLARITY, r & 8'h0F, RESP_OKAY);
      wr(OFF_SHUTDOWN, r & 8'h7F, RESP_OKAY); rd(OFF_SHUTDOWN, r & 8'h7C, RESP_OKAY);
    end
    wr(OFF_SHUTDOWN, 8'h14, RESP_OKAY);
    $display("test register_access done");
    // asynchronous steering with random source, polarity and steering
    wr(OFF_MODULE_CTRL, 8'h80, RESP_OKAY);
    chk({4'h0, m_en, mode_f}, 8'h08, "enable and mode");
    for (int k = 0; k < 8; k++) begin
      r = rnd() % 14; inv = 4'(rnd()); st = rnd();
      wr(OFF_POLARITY, {4'h0, inv}, RESP_OKAY); wr(OFF_DATA_SEL, r, RESP_OKAY);
      wr(OFF_STEERING, st, RESP_OKAY);
      for (int v = 0; v < 2; v++) begin
        put_data(r[3:0], v[0]);
        pins_are(exp_steer(v[0], inv, st));
        rd(OFF_POLARITY, {2'h0, v[0], 1'b0, inv}, RESP_OKAY);
      end
    end
    // outside the steering modes the steering bits have no effect
    wr(OFF_MODULE_CTRL, 8'h82, RESP_OKAY); rd(OFF_MODULE_CTRL, 8'h82, RESP_OKAY);
    @(posedge ref_clk);
    mode_wave <= 4'(rnd());
    repeat (3) @(posedge ref_clk);
    pins_are({4'h0, mode_wave ^ inv});
    $display("test steering done");
    // synchronous steering: enables load only at a data rising edge
    wr(OFF_POLARITY, 8'h00, RESP_OKAY);
    wr(OFF_MODULE_CTRL, 8'h81, RESP_OKAY);
    put_data(r[3:0], 1'b0);
    wr(OFF_STEERING, 8'h00, RESP_OKAY);
    put_data(r[3:0], 1'b1);
    pins_are(8'h00);
    wr(OFF_STEERING, 8'h0F, RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    pins_are(8'h00);
    rd(OFF_STEERING, 8'h0F, RESP_OKAY);
    put_data(r[3:0], 1'b0);
    put_data(r[3:0], 1'b1);
    pins_are(8'h0F);
    $display("test sync_steering done");
    // hardware shutdown, every halt code, refused clear, auto-restart, hold to data edge
    inv = 4'(rnd() | 8'h01);
    wr(OFF_POLARITY, {4'h0, inv}, RESP_OKAY);
    wr(OFF_MODULE_CTRL, 8'h80, RESP_OKAY);
    put_data(r[3:0], 1'b0);
    k0 = n_irq;
    @(posedge ref_clk);
    sd_cond <= 1'b1; db_done <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(OFF_SHUTDOWN, 8'h94, RESP_OKAY);
    chk(8'(n_irq - k0), 8'h01, "flag pulses");
    for (int c = 0; c < 4; c++) begin
      wr(OFF_SHUTDOWN, {2'h2, c[1:0], 2'(3 - c), 2'h0}, RESP_OKAY);
      repeat (2) @(posedge ref_clk);
      pins_are(exp_halt(c[1:0], 2'(3 - c), inv));
    end
    wr(OFF_SHUTDOWN, 8'h3C, RESP_OKAY);
    rd(OFF_SHUTDOWN, 8'hBC, RESP_OKAY);
    wr(OFF_SHUTDOWN, 8'hFC, RESP_OKAY);
    @(posedge ref_clk);
    sd_cond <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(OFF_SHUTDOWN, 8'h7C, RESP_OKAY);
    pins_are(8'h0F);
    put_data(r[3:0], 1'b1);
    pins_are({4'h0, 4'hF ^ inv});
    $display("test shutdown done");
    // software shutdown while disabled, then software restart
    wr(OFF_MODULE_CTRL, 8'h00, RESP_OKAY);
    k0 = n_irq;
    wr(OFF_SHUTDOWN, 8'hB4, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    rd(OFF_SHUTDOWN, 8'hB4, RESP_OKAY);
    pins_are(exp_halt(2'h3, 2'h1, inv));
    chk(8'(n_irq - k0), 8'h01, "flag pulses");
    wr(OFF_SHUTDOWN, 8'h34, RESP_OKAY);
    rd(OFF_SHUTDOWN, 8'h34, RESP_OKAY);
    $display("test disabled_shutdown done");
    finish_test();
  end
endmodule

/* verilog/wave_steer_pkg.sv */
// shared constants for the waveform steering and shutdown block
package wave_steer_pkg;
  // register bus geometry
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register byte offsets
  localparam logic [AXI_ADDR_W-1:0] OFF_POLARITY = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] OFF_CLOCK_SEL = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OFF_DATA_SEL = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] OFF_STEERING = 8'h0C;
  localparam logic [AXI_ADDR_W-1:0] OFF_SHUTDOWN = 8'h10;
  localparam logic [AXI_ADDR_W-1:0] OFF_MODULE_CTRL = 8'h14;
  // field positions
  localparam int IN_BIT = 5;
  localparam int SHUT_BIT = 7;
  localparam int REN_BIT = 6;
  localparam int BD_LSB = 4;
  localparam int AC_LSB = 2;
  localparam int OVR_LSB = 4;
  localparam int EN_BIT = 7;
  // reset values
  localparam logic [3:0] POLARITY_RST = 4'h0;
  localparam logic [3:0] DATA_SEL_RST = 4'h0;
  localparam logic [7:0] STEERING_RST = 8'h00;
  localparam logic [1:0] HALT_LEVEL_RST = 2'h1;
  localparam logic [2:0] MODE_RST = 3'h0;
  // halt level codes
  localparam logic [1:0] HALT_INACTIVE = 2'h0;
  localparam logic [1:0] HALT_FLOAT = 2'h1;
  localparam logic [1:0] HALT_LOW = 2'h2;
  localparam logic [1:0] HALT_HIGH = 2'h3;
  // output modes
  localparam logic [2:0] MODE_ASYNC_STEER = 3'h0;
  localparam logic [2:0] MODE_SYNC_STEER = 3'h1;
  // number of data source codes that name a source
  localparam int SRC_CODES = 14;
endpackage

/* verilog/waveform_steering_shutdown.sv */
// output polarity, steering and auto-shutdown control with an axi4-lite register slave
// Function
// - input waveform level readable, read-only bit five
// - per-output polarity bit inverts that output
// - clock-select bit picks module clock source
// - four-bit code selects data waveform source
// - steering enabled: output is data with polarity
// - steering disabled: output takes override bit
// - steering bits matter only in modes 00x
// - sync steering mode double-buffers steering enables
// - shutdown status set by events, readable
// - auto-restart bit, else software clears shutdown
// - b/d halt code drives high/low/float
// - b/d code 00: inactive level after dead-band
// - a/c halt code with same encoding
// - shutdown bit writable while module disabled
// - override holds until next data rising edge
// - unimplemented bits read zero, writes ignored
// - shutdown becoming set raises interrupt flag
// - auto-restart clears shutdown once conditions gone
// - software clear ignored while condition present
// - shutdown requests are level sensitive
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
module waveform_steering_shutdown #(
  parameter int NUM_SRC = 14 // data sources wired to WAVE_SRC
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // axi4-lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [wave_steer_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR,
  // axi4-lite write data
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [wave_steer_pkg::AXI_DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // axi4-lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // axi4-lite read address
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [wave_steer_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
  // axi4-lite read data
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [wave_steer_pkg::AXI_DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // candidate data waveforms, index equals source code
  input wire logic [NUM_SRC-1:0] WAVE_SRC,
  // from mode decoder and dead-band logic
  input wire logic [3:0] MODE_WAVE,
  input wire logic DEADBAND_DONE,
  input wire logic SHUTDOWN_COND,
  // to mode decoder, clock mux and interrupt logic
  output logic MODULE_ENABLE,
  output logic [2:0] MODE_FIELD,
  output logic MODULE_CLOCK_VALUE,
  output logic GENERATOR_INTERRUPT_FLAG,
  // waveform outputs with active-low enables
  output logic WAVEFORM_OUTPUT_A,
  output logic WAVEFORM_OUTPUT_A_OE_N,
  output logic WAVEFORM_OUTPUT_B,
  output logic WAVEFORM_OUTPUT_B_OE_N,
  output logic WAVEFORM_OUTPUT_C,
  output logic WAVEFORM_OUTPUT_C_OE_N,
  output logic WAVEFORM_OUTPUT_D,
  output logic WAVEFORM_OUTPUT_D_OE_N
);
  import wave_steer_pkg::*;

  // refuse source counts that would collide with reserved codes, at elaboration
  if (NUM_SRC < 1 || NUM_SRC > SRC_CODES) begin : g_bad_num_src
    $error("NUM_SRC must be 1 to 14");
  end

  // bus slave state
  logic awready_r; // write address ready
  logic wready_r; // write data ready
  logic aw_hold_r; // address held, waiting for data
  logic w_hold_r; // data held, waiting for address
  logic [AXI_ADDR_W-1:0] aw_addr_r; // held write address
  logic [7:0] w_data_r; // held low byte of write data
  logic w_steer_enable_b_r; // held lane-0 strobe
  logic bvalid_r; // write response pending
  logic [1:0] bresp_r; // write response code
  logic arready_r; // read address ready
  logic rvalid_r; // read data pending
  logic [7:0] rdata_r; // read byte, upper lanes zero
  logic [1:0] rresp_r; // read response code

  // register contents
  logic [3:0] invert_r; // invert_out_d..invert_out_a
  logic clk_sel_r; // module clock choice
  logic [3:0] waveform_source_select_r; // data source code
  logic [3:0] steer_shadow_r; // steering enables as written
  logic [3:0] steer_act_r; // steering enables in use
  logic [3:0] override_level_r; // override_level_d..a
  logic shut_r; // shutdown status
  logic restart_en_r; // auto-restart enable
  logic [1:0] halt_level_pair_bd_r; // halt code for b/d
  logic [1:0] halt_level_pair_ac_r; // halt code for a/c
  logic en_r; // module enable
  logic [2:0] mode_r; // output mode

  // datapath state
  logic data_d_r; // data waveform one cycle late
  logic hold_r; // outputs held at halt levels
  logic irq_r; // interrupt flag pulse
  logic [3:0] out_r; // output levels
  logic [3:0] oe_n_r; // output enables, low drives

  // handshake decode
  wire aw_take = S_AXI_AWVALID & awready_r;
  wire w_take = S_AXI_WVALID & wready_r;
  wire wr_fire = aw_hold_r & w_hold_r & ~bvalid_r;
  wire ar_take = S_AXI_ARVALID & arready_r;
  wire aw_hold_nxt = (aw_hold_r & ~wr_fire) | aw_take;
  wire w_hold_nxt = (w_hold_r & ~wr_fire) | w_take;
  wire bvalid_nxt = (bvalid_r & ~S_AXI_BREADY) | wr_fire;
  wire rvalid_nxt = (rvalid_r & ~S_AXI_RREADY) | ar_take;

  // write address decode on the held address
  wire [AXI_ADDR_W-1:0] wr_word = {aw_addr_r[AXI_ADDR_W-1:2], 2'h0};
  wire wr_hit_pol = (wr_word == OFF_POLARITY);
  wire wr_hit_clk = (wr_word == OFF_CLOCK_SEL);
  wire wr_hit_dat = (wr_word == OFF_DATA_SEL);
  wire wr_hit_str = (wr_word == OFF_STEERING);
  wire wr_hit_shut = (wr_word == OFF_SHUTDOWN);
  wire wr_hit_ctl = (wr_word == OFF_MODULE_CTRL);
  wire wr_hit = wr_hit_pol | wr_hit_clk | wr_hit_dat | wr_hit_str | wr_hit_shut | wr_hit_ctl;
  // only lane 0 carries register bits; other lanes are ignored
  wire wr_do = wr_fire & w_steer_enable_b_r;
  wire wr_pol = wr_do & wr_hit_pol;
  wire wr_clk = wr_do & wr_hit_clk;
  wire wr_dat = wr_do & wr_hit_dat;
  wire wr_str = wr_do & wr_hit_str;
  wire wr_shut = wr_do & wr_hit_shut;
  wire wr_ctl = wr_do & wr_hit_ctl;

  // read decode and read-back mux, reserved bits read zero
  wire [AXI_ADDR_W-1:0] rd_word = {S_AXI_ARADDR[AXI_ADDR_W-1:2], 2'h0};
  wire [7:0] rd_pol = {2'h0, data_d_r, 1'b0, invert_r};
  wire [7:0] rd_clk = {7'h00, clk_sel_r};
  wire [7:0] rd_dat = {4'h0, waveform_source_select_r};
  wire [7:0] rd_str = {override_level_r, steer_shadow_r};
  wire [7:0] rd_shut = {shut_r, restart_en_r, halt_level_pair_bd_r, halt_level_pair_ac_r, 2'h0};
  wire [7:0] rd_ctl = {en_r, 4'h0, mode_r};
  wire rd_hit_pol = (rd_word == OFF_POLARITY);
  wire rd_hit_clk = (rd_word == OFF_CLOCK_SEL);
  wire rd_hit_dat = (rd_word == OFF_DATA_SEL);
  wire rd_hit_str = (rd_word == OFF_STEERING);
  wire rd_hit_shut = (rd_word == OFF_SHUTDOWN);
  wire rd_hit_ctl = (rd_word == OFF_MODULE_CTRL);
  wire rd_hit = rd_hit_pol | rd_hit_clk | rd_hit_dat | rd_hit_str | rd_hit_shut | rd_hit_ctl;
  wire [7:0] rd_mux = ({8{rd_hit_pol}} & rd_pol) | ({8{rd_hit_clk}} & rd_clk) |
                      ({8{rd_hit_dat}} & rd_dat) | ({8{rd_hit_str}} & rd_str) |
                      ({8{rd_hit_shut}} & rd_shut) | ({8{rd_hit_ctl}} & rd_ctl);

  // data source selection; reserved codes pick a zero pad bit
  wire [15:0] src_pad = 16'(WAVE_SRC);
  wire data_now = src_pad[waveform_source_select_r];
  wire rise = data_now & ~data_d_r;
  wire steer_mode = (mode_r[2:1] == MODE_ASYNC_STEER[2:1]);

  // shutdown status: set beats every clear
  wire sw_set = wr_shut & w_data_r[SHUT_BIT];
  wire sw_clr = wr_shut & ~w_data_r[SHUT_BIT] & ~SHUTDOWN_COND;
  wire hw_set = en_r & SHUTDOWN_COND;
  wire auto_clr = restart_en_r & ~SHUTDOWN_COND;
  wire shut_nxt = hw_set | sw_set | (shut_r & ~(auto_clr | sw_clr));
  // override released only at a data rising edge after the clear
  wire hold_nxt = shut_nxt | (hold_r & ~rise);

  // steering enables in use: direct in async mode, edge-loaded in sync mode
  wire [3:0] steer_act_nxt = (mode_r == MODE_ASYNC_STEER) ? steer_shadow_r :
                             ((mode_r == MODE_SYNC_STEER) && rise) ? steer_shadow_r : steer_act_r;

  // per-output level selection
  logic [3:0] out_nxt;
  logic [3:0] oe_n_nxt;
  for (genvar i = 0; i < 4; i++) begin : g_out
    // a and c share one halt code, b and d the other
    wire [1:0] code = (i % 2 == 0) ? halt_level_pair_ac_r : halt_level_pair_bd_r;
    wire steered = steer_act_r[i] ? (data_now ^ invert_r[i]) : override_level_r[i];
    wire moded = MODE_WAVE[i] ^ invert_r[i];
    wire normal = ~en_r ? invert_r[i] : (steer_mode ? steered : moded);
    // inactive level waits for dead-band; until then the old level stays
    wire inactive = DEADBAND_DONE ? invert_r[i] : out_r[i];
    wire halted = (code == HALT_HIGH) ? 1'b1 :
                  (code == HALT_LOW) ? 1'b0 :
                  (code == HALT_FLOAT) ? out_r[i] : inactive;
    assign out_nxt[i] = hold_nxt ? halted : normal;
    assign oe_n_nxt[i] = hold_nxt & (code == HALT_FLOAT);
  end

  // write-channel handshake registers
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid_r <= 1'b0;
    end else begin
      // ready drops while a beat is held or a response waits
      awready_r <= ~aw_hold_nxt & ~bvalid_nxt;
      wready_r <= ~w_hold_nxt & ~bvalid_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      bvalid_r <= bvalid_nxt;
    end
  end

  // write payload capture and response code
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      aw_addr_r <= '0;
      w_data_r <= 8'h00;
      w_steer_enable_b_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (aw_take) aw_addr_r <= S_AXI_AWADDR;
      if (w_take) w_data_r <= S_AXI_WDATA[7:0];
      if (w_take) w_steer_enable_b_r <= S_AXI_WSTRB[0];
      // unmapped offsets answer slverr and store nothing
      if (wr_fire) bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 8'h00;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_take) rdata_r <= rd_mux;
      if (ar_take) rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // configuration registers; only implemented bits are stored
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      invert_r <= POLARITY_RST;
      clk_sel_r <= 1'b0;
      waveform_source_select_r <= DATA_SEL_RST;
      steer_shadow_r <= STEERING_RST[3:0];
      override_level_r <= STEERING_RST[7:4];
      en_r <= 1'b0;
      mode_r <= MODE_RST;
    end else begin
      if (wr_pol) invert_r <= w_data_r[3:0];
      if (wr_clk) clk_sel_r <= w_data_r[0];
      if (wr_dat) waveform_source_select_r <= w_data_r[3:0];
      if (wr_str) steer_shadow_r <= w_data_r[3:0];
      if (wr_str) override_level_r <= w_data_r[OVR_LSB +: 4];
      if (wr_ctl) en_r <= w_data_r[EN_BIT];
      if (wr_ctl) mode_r <= w_data_r[2:0];
    end
  end

  // shutdown control register and status
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      shut_r <= 1'b0;
      restart_en_r <= 1'b0;
      halt_level_pair_bd_r <= HALT_LEVEL_RST;
      halt_level_pair_ac_r <= HALT_LEVEL_RST;
    end else begin
      shut_r <= shut_nxt;
      if (wr_shut) restart_en_r <= w_data_r[REN_BIT];
      if (wr_shut) halt_level_pair_bd_r <= w_data_r[BD_LSB +: 2];
      if (wr_shut) halt_level_pair_ac_r <= w_data_r[AC_LSB +: 2];
    end
  end

  // waveform path and output flops
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      data_d_r <= 1'b0;
      steer_act_r <= STEERING_RST[3:0];
      hold_r <= 1'b0;
      irq_r <= 1'b0;
      out_r <= 4'h0;
      oe_n_r <= 4'h0;
    end else begin
      data_d_r <= data_now;
      steer_act_r <= steer_act_nxt;
      hold_r <= hold_nxt;
      irq_r <= shut_nxt & ~shut_r;
      out_r <= out_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  // port drive, all from flops
  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY = wready_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = {24'h00_0000, rdata_r};
  assign S_AXI_RRESP = rresp_r;
  assign MODULE_ENABLE = en_r;
  assign MODE_FIELD = mode_r;
  assign MODULE_CLOCK_VALUE = clk_sel_r;
  assign GENERATOR_INTERRUPT_FLAG = irq_r;
  assign WAVEFORM_OUTPUT_A = out_r[0];
  assign WAVEFORM_OUTPUT_B = out_r[1];
  assign WAVEFORM_OUTPUT_C = out_r[2];
  assign WAVEFORM_OUTPUT_D = out_r[3];
  assign WAVEFORM_OUTPUT_A_OE_N = oe_n_r[0];
  assign WAVEFORM_OUTPUT_B_OE_N = oe_n_r[1];
  assign WAVEFORM_OUTPUT_C_OE_N = oe_n_r[2];
  assign WAVEFORM_OUTPUT_D_OE_N = oe_n_r[3];

  // checks on the design's own behaviour
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_sw_halt;
    ~en_r && sw_set;
  endsequence

  sequence s_release_wait;
    hold_r && ~shut_nxt && ~rise;
  endsequence

  a_in_bit_read: assert property (ar_take && rd_hit_pol |=> S_AXI_RDATA[IN_BIT] == $past(data_d_r))
    else $error("data level bit wrong on read");
  a_steer_polarity: assert property (en_r && steer_mode && steer_act_r[0] && ~hold_nxt
    |=> WAVEFORM_OUTPUT_A == ($past(data_now) ^ $past(invert_r[0])))
    else $error("steered output a wrong");
  a_clock_select: assert property (wr_clk |=> MODULE_CLOCK_VALUE == $past(w_data_r[0]))
    else $error("clock select not stored");
  a_reserved_src: assert property (waveform_source_select_r >= 4'hE |-> ~data_now)
    else $error("reserved source not zero");
  a_override_bit: assert property (en_r && steer_mode && ~steer_act_r[1] && ~hold_nxt
    |=> WAVEFORM_OUTPUT_B == $past(override_level_r[1]))
    else $error("override level b wrong");
  a_other_mode: assert property (en_r && ~steer_mode && ~hold_nxt
    |=> WAVEFORM_OUTPUT_C == ($past(MODE_WAVE[2]) ^ $past(invert_r[2])))
    else $error("non-steering output c wrong");
  a_sync_buffer: assert property (mode_r == MODE_SYNC_STEER && ~rise |=> steer_act_r == $past(steer_act_r))
    else $error("sync steering changed off edge");
  a_sync_load: assert property (mode_r == MODE_SYNC_STEER && rise |=> steer_act_r == $past(steer_shadow_r))
    else $error("sync steering not loaded on edge");
  a_sw_clear: assert property (shut_r && wr_shut && ~w_data_r[SHUT_BIT] && ~SHUTDOWN_COND |=> ~shut_r)
    else $error("software clear lost");
  a_bd_float: assert property (hold_nxt && halt_level_pair_bd_r == HALT_FLOAT |=> WAVEFORM_OUTPUT_B_OE_N)
    else $error("b not floated");
  a_bd_inactive: assert property (hold_nxt && halt_level_pair_bd_r == HALT_INACTIVE && DEADBAND_DONE
    |=> WAVEFORM_OUTPUT_D == $past(invert_r[3]) && ~WAVEFORM_OUTPUT_D_OE_N)
    else $error("d not at inactive level");
  a_ac_high: assert property (hold_nxt && halt_level_pair_ac_r == HALT_HIGH
    |=> WAVEFORM_OUTPUT_A && ~WAVEFORM_OUTPUT_A_OE_N)
    else $error("a not driven high in shutdown");
  a_disabled_halt: assert property (s_sw_halt |=> shut_r && hold_r)
    else $error("shutdown write while disabled lost");
  a_hold_release: assert property (s_release_wait |=> hold_r)
    else $error("override released early");
  a_resume_edge: assert property (hold_r && ~shut_nxt && rise |=> ~hold_r)
    else $error("no resume at data edge");
  a_reserved_zero: assert property (ar_take && rd_hit_shut |=> S_AXI_RDATA[1:0] == 2'h0)
    else $error("reserved bits not zero");
  a_irq_on_set: assert property ($rose(shut_r) |-> GENERATOR_INTERRUPT_FLAG ##1 ~GENERATOR_INTERRUPT_FLAG)
    else $error("interrupt flag not pulsed");
  a_auto_restart: assert property (shut_r && restart_en_r && ~SHUTDOWN_COND && ~sw_set |=> ~shut_r)
    else $error("auto restart did not clear");
  a_clear_blocked: assert property (shut_r && SHUTDOWN_COND |=> shut_r)
    else $error("shutdown cleared while condition present");
endmodule
